/* logic/nts_bridge_pkg.sv */
// Constants and types shared by the narrow time bus bridge
package timebridge_pkg;
   // ==========================================================
   // Widths and default sizing
   localparam int TS_W      = 7;   // narrow increment per packet
   localparam int SYNC_W    = 2;   // synchronization channel
   localparam int DEPTH     = 4;   // message buffer entries
   localparam int LAG_W     = 16;  // lag counter width
   localparam int THRESHOLD = 16;  // lag above which a resync is forced

   // ==========================================================
   // Reset values
   localparam logic RST_ACCEPT_N = 1'b1;
   localparam logic RST_VALID    = 1'b0;

   // ==========================================================
   // State encodings
   typedef enum logic [3:0] {
      ST_RESYNC = 4'h1,
      ST_RUN    = 4'h2,
      ST_FLUSH  = 4'h4,
      ST_OFF    = 4'h8
   } bridge_state_t;

   typedef enum logic [1:0] {
      Q_RUN  = 2'h1,
      Q_STOP = 2'h2
   } q_state_t;
endpackage

/* logic/low_power_handshake.sv */
// Clock low power handshake (request, accept, activity)
`timescale 1ns/10ps
`default_nettype none
module low_power_handshake (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic qreqN,
   input  wire logic idle,
   input  wire logic wake,
   output logic      qacceptN,
   output logic      qactive,
   output logic      gated,
   output logic      woke
);
   typedef struct packed {
      timebridge_pkg::q_state_t st;
      logic                     woke;
   } q_reg_t;

   q_reg_t r;
   q_reg_t next_r;

   always_comb begin
      next_r = r;
      next_r.woke = 1'b0;
      case (r.st)
         timebridge_pkg::Q_RUN: begin
            if (!qreqN && idle) begin
               next_r.st = timebridge_pkg::Q_STOP;
            end
         end
         timebridge_pkg::Q_STOP: begin
            if (qreqN) begin
               next_r.st = timebridge_pkg::Q_RUN;
               next_r.woke = 1'b1;
            end
         end
         default: next_r.st = timebridge_pkg::Q_RUN;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r.st <= timebridge_pkg::Q_RUN;
         r.woke <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign gated = (r.st == timebridge_pkg::Q_STOP);
   assign qacceptN = !gated;
   assign qactive = wake;
   assign woke = r.woke;
endmodule
`default_nettype wire

/* logic/ts_msg_buffer.sv */
// Message buffer for timestamp increments
`timescale 1ns/10ps
`default_nettype none
module ts_msg_buffer #(
   parameter int W     = timebridge_pkg::TS_W,
   parameter int DEPTH = timebridge_pkg::DEPTH
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic         flush,
   input  wire logic         push,
   input  wire logic [W-1:0] pushData,
   input  wire logic         pop,
   output logic [W-1:0]      popData,
   output logic              empty,
   output logic              full
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("Buffer depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wr;
      logic [AW:0]             rd;
   } buf_reg_t;

   buf_reg_t r;
   buf_reg_t next_r;

   assign empty = (r.wr == r.rd);
   assign full  = (r.wr[AW-1:0] == r.rd[AW-1:0]) && (r.wr[AW] != r.rd[AW]);
   assign popData = r.mem[r.rd[AW-1:0]];

   always_comb begin
      next_r = r;
      if (flush) begin
         next_r.wr = '0;
         next_r.rd = '0;
      end else begin
         if (push && !full) begin
            next_r.mem[r.wr[AW-1:0]] = pushData;
            next_r.wr = r.wr + 1'b1;
         end
         if (pop && !empty) begin
            next_r.rd = r.rd + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end
endmodule
`default_nettype wire

/* logic/narrow_timestamp_async_bridge.sv */
// Narrow time bus bridge with buffering, lag bound and low power handshakes
// Behaviour
// - Increments pass through a buffer; full resolution while the master keeps pace.
// - Slow master: packets merge, so fewer packets carry the same total time.
// - Power-down request drives slave synchronization ready high.
// - Power-down flushes every buffered message out before acknowledging.
// - Acknowledge only once the logic is safe for either side to lose power.
// - Power request high again: resynchronize and emit a resync event.
// - Power handshake has no activity output and never denies.
// - Slave clock gated: incoming slave packets are disregarded.
// - Power change while slave clock gated raises slave clock activity.
// - Master clock gated: slave sync ready is withheld at once; buffer fills.
// - Leaving master clock gating sends a resync packet.
// - Output lag bounded by the threshold plus a full buffer and one more packet.
// - Lag beyond the threshold parameter forces a resync.
`timescale 1ns/10ps
`default_nettype none
module narrow_timestamp_async_bridge #(
   parameter int TS_W      = timebridge_pkg::TS_W,
   parameter int SYNC_W    = timebridge_pkg::SYNC_W,
   parameter int DEPTH     = timebridge_pkg::DEPTH,
   parameter int LAG_W     = timebridge_pkg::LAG_W,
   parameter int THRESHOLD = timebridge_pkg::THRESHOLD
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic [TS_W-1:0]   tsIncS,
   input  wire logic [SYNC_W-1:0] tsSyncS,
   input  wire logic              tsSyncValidS,
   output logic                   tsSyncReadyS,
   input  wire logic              mStrobe,
   output logic [TS_W-1:0]        tsIncM,
   output logic                   tsValidM,
   output logic                   resyncM,
   output logic [SYNC_W-1:0]      tsSyncM,
   output logic                   tsSyncValidM,
   input  wire logic              tsSyncReadyM,
   input  wire logic              pwrQreqN,
   output logic                   pwrQacceptN,
   input  wire logic              clkSQreqN,
   output logic                   clkSQacceptN,
   output logic                   clkSQactive,
   input  wire logic              clkMQreqN,
   output logic                   clkMQacceptN,
   output logic                   clkMQactive
);
   if (TS_W < 1 || SYNC_W < 1 || LAG_W <= TS_W || THRESHOLD < 1 || THRESHOLD >= (1 << (LAG_W - 1))) begin : g_chk
      $error("Bridge parameters out of range");
   end

   // ==========================================================
   // State
   typedef struct packed {
      timebridge_pkg::bridge_state_t st;
      logic [LAG_W-1:0]              lag;
      logic [TS_W-1:0]               acc;
      logic [TS_W-1:0]               outInc;
      logic                          outValid;
      logic [SYNC_W-1:0]             sync;
      logic                          syncValid;
      logic                          resync;
      logic                          acceptN;
   } bridge_reg_t;

   bridge_reg_t r;
   bridge_reg_t next_r;

   logic            sGated;
   logic            mGated;
   logic            mWoke;
   logic            bufEmpty;
   logic            bufFull;
   logic [TS_W-1:0] bufOut;
   logic            push;
   logic            pop;
   logic            flush;
   logic [TS_W-1:0] pushData;
   logic [TS_W:0]   total;
   logic [TS_W-1:0] sIn;
   logic            running;
   logic            pwrDown;
   logic            overLag;
   logic            clkSActivity;

   // ==========================================================
   // Clock handshakes and message buffer
   low_power_handshake u_clk_s (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .qreqN    (clkSQreqN),
      .idle     (1'b1),
      .wake     (clkSActivity),
      .qacceptN (clkSQacceptN),
      .qactive  (clkSQactive),
      .gated    (sGated),
      .woke     ()
   );

   low_power_handshake u_clk_m (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .qreqN    (clkMQreqN),
      .idle     (1'b1),
      .wake     (1'b0),
      .qacceptN (clkMQacceptN),
      .qactive  (clkMQactive),
      .gated    (mGated),
      .woke     (mWoke)
   );

   ts_msg_buffer #(
      .W     (TS_W),
      .DEPTH (DEPTH)
   ) u_buf (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .flush    (flush),
      .push     (push),
      .pushData (pushData),
      .pop      (pop),
      .popData  (bufOut),
      .empty    (bufEmpty),
      .full     (bufFull)
   );

   // ==========================================================
   // Datapath terms
   // Wake slave clock
   assign clkSActivity = sGated && (pwrQreqN == (r.st == timebridge_pkg::ST_OFF));

   assign running = (r.st == timebridge_pkg::ST_RUN);
   assign pwrDown = (r.st == timebridge_pkg::ST_FLUSH) || (r.st == timebridge_pkg::ST_OFF);
   assign sIn = (running && !sGated) ? tsIncS : '0;
   assign total = {1'b0, r.acc} + {1'b0, sIn};
   assign push = (running || r.st == timebridge_pkg::ST_FLUSH) && (total != '0) && !total[TS_W] && !bufFull;
   assign pushData = total[TS_W-1:0];
   assign pop = !bufEmpty && !mGated && mStrobe && (running || r.st == timebridge_pkg::ST_FLUSH);
   assign flush = (r.st == timebridge_pkg::ST_RESYNC);
   assign overLag = (r.lag > LAG_W'(THRESHOLD)) || total[TS_W];

   // ==========================================================
   // Next state
   always_comb begin
      next_r = r;
      next_r.outValid = 1'b0;
      next_r.resync = 1'b0;
      if (pop) begin
         next_r.outInc = bufOut;
         next_r.outValid = 1'b1;
      end
      next_r.lag = r.lag + LAG_W'(sIn) - (pop ? LAG_W'(bufOut) : LAG_W'(0));
      if (push) begin
         next_r.acc = '0;
      end else if (!total[TS_W]) begin
         next_r.acc = total[TS_W-1:0];
      end
      if (r.syncValid && tsSyncReadyM) begin
         next_r.syncValid = 1'b0;
      end
      if (tsSyncValidS && tsSyncReadyS && running && !sGated) begin
         next_r.sync = tsSyncS;
         next_r.syncValid = 1'b1;
      end
      case (r.st)
         timebridge_pkg::ST_RESYNC: begin
            next_r.lag = '0;
            next_r.acc = '0;
            next_r.resync = 1'b1;
            next_r.st = timebridge_pkg::ST_RUN;
         end
         timebridge_pkg::ST_RUN: begin
            if (!pwrQreqN) begin
               next_r.st = timebridge_pkg::ST_FLUSH;
            end else if (overLag || mWoke) begin
               next_r.st = timebridge_pkg::ST_RESYNC;
            end
         end
         timebridge_pkg::ST_FLUSH: begin
            if (bufEmpty && r.acc == '0 && !r.syncValid) begin
               next_r.st = timebridge_pkg::ST_OFF;
               next_r.acceptN = 1'b0;
            end
         end
         timebridge_pkg::ST_OFF: begin
            if (pwrQreqN) begin
               next_r.st = timebridge_pkg::ST_RESYNC;
               next_r.acceptN = 1'b1;
            end
         end
         default: next_r.st = timebridge_pkg::ST_RESYNC;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         r <= '0;
         r.st <= timebridge_pkg::ST_RESYNC;
         r.acceptN <= timebridge_pkg::RST_ACCEPT_N;
         r.outValid <= timebridge_pkg::RST_VALID;
      end else begin
         r <= next_r;
      end
   end

   // ==========================================================
   // Outputs
   // Ready high in power down
   assign tsSyncReadyS = pwrDown || (running && !bufFull && !mGated && (!r.syncValid || tsSyncReadyM));
   assign tsIncM = r.outInc;
   assign tsValidM = r.outValid;
   assign resyncM = r.resync;
   assign tsSyncM = r.sync;
   assign tsSyncValidM = r.syncValid;
   assign pwrQacceptN = r.acceptN;

   // ==========================================================
   // Checks
   sequence s_flushDone;
      bufEmpty && r.acc == '0 && !r.syncValid;
   endsequence

   sequence s_resyncOut;
      ##[1:2] resyncM;
   endsequence

   property p_readyPwrDown;
      @(posedge mclk) disable iff (!rst_n) !pwrQacceptN |-> tsSyncReadyS;
   endproperty
   a_readyPwrDown: assert property (p_readyPwrDown) else $error("Sync ready low in power down");

   property p_flushBeforeAck;
      @(posedge mclk) disable iff (!rst_n) $fell(pwrQacceptN) |-> $past(bufEmpty) && r.lag == LAG_W'(0) || bufEmpty;
   endproperty
   a_flushBeforeAck: assert property (p_flushBeforeAck) else $error("Ack with buffered data");

   property p_safeOff;
      @(posedge mclk) disable iff (!rst_n) !pwrQacceptN |-> s_flushDone;
   endproperty
   a_safeOff: assert property (p_safeOff) else $error("Not safe while acknowledged");

   property p_powerUpResync;
      @(posedge mclk) disable iff (!rst_n) $rose(pwrQacceptN) |-> s_resyncOut;
   endproperty
   a_powerUpResync: assert property (p_powerUpResync) else $error("No resync after power up");

   property p_ackFollowsFlush;
      @(posedge mclk) disable iff (!rst_n) ((r.st == timebridge_pkg::ST_FLUSH) and s_flushDone) |=> !pwrQacceptN;
   endproperty
   a_ackFollowsFlush: assert property (p_ackFollowsFlush) else $error("Power down not accepted");

   property p_gatedIgnore;
      @(posedge mclk) disable iff (!rst_n) running && sGated && !pop && r.acc == '0 |=> r.lag == $past(r.lag);
   endproperty
   a_gatedIgnore: assert property (p_gatedIgnore) else $error("Packet taken while gated");

   property p_slaveWake;
      @(posedge mclk) disable iff (!rst_n) sGated && running && !pwrQreqN |-> clkSQactive;
   endproperty
   a_slaveWake: assert property (p_slaveWake) else $error("No slave clock activity");

   property p_stallFull;
      @(posedge mclk) disable iff (!rst_n) bufFull && running |-> !tsSyncReadyS;
   endproperty
   a_stallFull: assert property (p_stallFull) else $error("Ready while buffer full");

   property p_masterWake;
      @(posedge mclk) disable iff (!rst_n) mWoke && running && pwrQreqN |-> s_resyncOut;
   endproperty
   a_masterWake: assert property (p_masterWake) else $error("No resync after master wake");

   property p_threshold;
      @(posedge mclk) disable iff (!rst_n) running && pwrQreqN && r.lag > LAG_W'(THRESHOLD) |-> s_resyncOut;
   endproperty
   a_threshold: assert property (p_threshold) else $error("Lag threshold without resync");

   property p_lagBound;
      @(posedge mclk) disable iff (!rst_n) r.lag <= LAG_W'(THRESHOLD) + LAG_W'(DEPTH << TS_W) + LAG_W'(1 << TS_W);
   endproperty
   a_lagBound: assert property (p_lagBound) else $error("Lag beyond bound");

   property p_resetResync;
      @(posedge mclk) $rose(rst_n) |-> !tsValidM ##1 resyncM;
   endproperty
   a_resetResync: assert property (p_resetResync) else $error("No resync after reset");
endmodule
`default_nettype wire

/* sim/nts_rx_model.sv */
// Downstream receiver model: paced strobe, sync ready, running totals
`timescale 1ns/10ps
`default_nettype none
module time_rx_model (
   input  wire logic                           mclk,
   input  wire logic                           rst_n,
   input  wire logic [3:0]                     rate,
   input  wire logic [timebridge_pkg::TS_W-1:0] tsIncM,
   input  wire logic                           tsValidM,
   input  wire logic                           resyncM,
   output logic                                mStrobe,
   output logic                                tsSyncReadyM,
   output logic [15:0]                         rxSum,
   output logic [7:0]                          rxResync
);
   logic [3:0] cnt;
   initial begin
      mStrobe = 1'b0;
      tsSyncReadyM = 1'b0;
   end
   // ==========================================
   // Pacing off the falling edge; rate 0 stalls
   // receiver keeps clocking
   always @(negedge mclk) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         rxSum <= 16'h0000;
         rxResync <= 8'h00;
         mStrobe <= 1'b0;
         tsSyncReadyM <= 1'b0;
      end else begin
         mStrobe <= (rate != 4'h0) && (cnt == 4'h0);
         cnt <= (rate == 4'h0 || cnt == 4'h0) ? rate - 4'h1 : cnt - 4'h1;
         tsSyncReadyM <= (rate != 4'h0);
         if (tsValidM === 1'b1) rxSum <= rxSum + 16'(tsIncM);
         if (resyncM === 1'b1) rxResync <= rxResync + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* sim/narrow_timestamp_async_bridge_tb.sv */
// Self-checking bench for the narrow time bus bridge
`timescale 1ns/10ps
`default_nettype none
module narrow_timestamp_async_bridge_tb;
   logic       mclk = 1'b0;
   logic       rst_n;
   logic [6:0] tsIncS, tsIncM;
   logic [1:0] tsSyncS, tsSyncM;
   logic       tsSyncValidS, tsSyncReadyS, mStrobe, tsValidM, resyncM;
   logic       tsSyncValidM, tsSyncReadyM, pwrQreqN, pwrQacceptN;
   logic       clkSQreqN, clkSQacceptN, clkSQactive;
   logic       clkMQreqN, clkMQacceptN, clkMQactive;
   logic [3:0] rate;
   logic [15:0] rxSum, s0;
   logic [7:0] rxResync, r0;
   logic [7:0] lf = 8'h44;
   logic       exact = 1'b0;
   logic       syncChk = 1'b0;
   logic [6:0] expQ[$];
   logic [1:0] syncQ[$];
   int         errorCnt = 0;
   int         checksDone = 0;
   int         pktCnt = 0;
   int         p0;

   always #25 mclk = ~mclk;

   narrow_timestamp_async_bridge narrow_timestamp_async_bridge_inst (
      .mclk(mclk), .rst_n(rst_n), .tsIncS(tsIncS), .tsSyncS(tsSyncS),
      .tsSyncValidS(tsSyncValidS), .tsSyncReadyS(tsSyncReadyS), .mStrobe(mStrobe),
      .tsIncM(tsIncM), .tsValidM(tsValidM), .resyncM(resyncM), .tsSyncM(tsSyncM),
      .tsSyncValidM(tsSyncValidM), .tsSyncReadyM(tsSyncReadyM), .pwrQreqN(pwrQreqN),
      .pwrQacceptN(pwrQacceptN), .clkSQreqN(clkSQreqN), .clkSQacceptN(clkSQacceptN),
      .clkSQactive(clkSQactive), .clkMQreqN(clkMQreqN), .clkMQacceptN(clkMQacceptN),
      .clkMQactive(clkMQactive));

   time_rx_model time_rx_model_inst (
      .mclk(mclk), .rst_n(rst_n), .rate(rate), .tsIncM(tsIncM), .tsValidM(tsValidM),
      .resyncM(resyncM), .mStrobe(mStrobe), .tsSyncReadyM(tsSyncReadyM),
      .rxSum(rxSum), .rxResync(rxResync));

   // ==========================================
   // Helpers
   function automatic logic [7:0] nxt(input logic [7:0] x);
      nxt = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   function automatic logic sel(input int k);
      case (k)
         0: sel = pwrQacceptN;
         1: sel = clkSQacceptN;
         2: sel = clkMQacceptN;
         3: sel = tsSyncReadyS;
         default: sel = clkSQactive;
      endcase
   endfunction

   task automatic closeOut();
      $display("checks %0d errors %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checksDone++;
      if (e !== g) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic waitLvl(input int k, input logic lv, input int n);
      int i;
      for (i = 0; i < n && sel(k) !== lv; i++) @(negedge mclk);
      chk("handshake level", {15'h0, lv}, {15'h0, sel(k)});
      if (sel(k) !== lv) closeOut();
   endtask

   // Start count taken before the trigger, so an early pulse is not missed
   task automatic waitRs(input logic [7:0] c0, input int n);
      int i;
      for (i = 0; i < n && rxResync === c0; i++) @(negedge mclk);
      chk("resync seen", 16'h0001, (rxResync !== c0) ? 16'h0001 : 16'h0000);
      if (rxResync === c0) closeOut();
   endtask

   task automatic drv(input logic [6:0] v, input int n);
      repeat (n) begin
         tsIncS = v;
         if (exact) expQ.push_back(v);
         @(negedge mclk);
      end
      tsIncS = 7'h00;
      @(negedge mclk);
   endtask

   task automatic sendSync(input logic [1:0] d);
      int i;
      tsSyncS = d;
      tsSyncValidS = 1'b1;
      // Ready seen at the falling edge holds through the taking edge
      for (i = 0; i < 20 && tsSyncReadyS !== 1'b1; i++) @(negedge mclk);
      chk("sync taken", 16'h0001, {15'h0, tsSyncReadyS});
      syncQ.push_back(d);
      @(negedge mclk);
      tsSyncValidS = 1'b0;
      @(negedge mclk);
   endtask

   // ==========================================
   // Output watcher
   always @(negedge mclk) begin
      if (tsValidM === 1'b1) begin
         pktCnt++;
         if (exact && expQ.size() == 0) chk("extra packet", 16'h0000, 16'h0001);
         else if (exact) chk("tsIncM", 16'(expQ.pop_front()), 16'(tsIncM));
      end
      if (syncChk && tsSyncValidM === 1'b1 && tsSyncReadyM === 1'b1 && syncQ.size() != 0)
         chk("tsSyncM", 16'(syncQ.pop_front()), 16'(tsSyncM));
   end

   // ==========================================
   // Main sequence
   initial begin
      tsIncS = 7'h00;
      tsSyncS = 2'h0;
      tsSyncValidS = 1'b0;
      pwrQreqN = 1'b1;
      clkSQreqN = 1'b1;
      clkMQreqN = 1'b1;
      rate = 4'h1;
      rst_n = 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk("pwrQacceptN", 16'h0001, {15'h0, pwrQacceptN});
      chk("tsValidM", 16'h0000, {15'h0, tsValidM});
      r0 = 8'h00;
      rst_n = 1'b1;
      waitRs(r0, 10);
      $display("test reset done");
      exact = 1'b1;
      repeat (12) begin
         lf = nxt(lf);
         drv((lf[2:0] == 3'h0) ? 7'h07 : {4'h0, lf[2:0]}, 1);
      end
      repeat (6) @(negedge mclk);
      chk("packets left", 16'h0000, 16'(expQ.size()));
      exact = 1'b0;
      syncChk = 1'b1;
      repeat (3) begin
         lf = nxt(lf);
         sendSync(lf[1:0]);
      end
      repeat (8) @(negedge mclk);
      chk("sync left", 16'h0000, 16'(syncQ.size()));
      syncChk = 1'b0;
      $display("test pass-through done");
      s0 = rxSum;
      p0 = pktCnt;
      r0 = rxResync;
      rate = 4'h4;
      drv(7'h01, 10);
      rate = 4'h1;
      repeat (20) @(negedge mclk);
      chk("merged sum", 16'h000A, rxSum - s0);
      chk("fewer packets", 16'h0001, ((pktCnt - p0) < 10) ? 16'h0001 : 16'h0000);
      chk("no resync", 16'(r0), 16'(rxResync));
      $display("test slow master done");
      r0 = rxResync;
      rate = 4'h0;
      drv(7'h07, 8);
      waitRs(r0, 40);
      rate = 4'h1;
      repeat (10) @(negedge mclk);
      $display("test threshold done");
      rate = 4'h0;
      drv(7'h02, 3);
      s0 = rxSum;
      r0 = rxResync;
      pwrQreqN = 1'b0;
      rate = 4'h1;
      waitLvl(0, 1'b0, 40);
      @(negedge mclk);
      chk("ready forced", 16'h0001, {15'h0, tsSyncReadyS});
      chk("flushed sum", 16'h0006, rxSum - s0);
      repeat (5) @(negedge mclk);
      chk("still accepted", 16'h0000, {15'h0, pwrQacceptN});
      pwrQreqN = 1'b1;
      waitLvl(0, 1'b1, 5);
      waitRs(r0, 10);
      $display("test power done");
      clkSQreqN = 1'b0;
      waitLvl(1, 1'b0, 5);
      p0 = pktCnt;
      drv(7'h05, 4);
      repeat (8) @(negedge mclk);
      chk("gated packets", 16'(p0), 16'(pktCnt));
      pwrQreqN = 1'b0;
      waitLvl(4, 1'b1, 5);
      clkSQreqN = 1'b1;
      waitLvl(1, 1'b1, 5);
      waitLvl(0, 1'b0, 40);
      r0 = rxResync;
      pwrQreqN = 1'b1;
      waitLvl(0, 1'b1, 5);
      waitRs(r0, 10);
      $display("test slave gating done");
      clkMQreqN = 1'b0;
      waitLvl(2, 1'b0, 5);
      chk("clkMQactive", 16'h0000, {15'h0, clkMQactive});
      tsSyncS = 2'h2;
      tsSyncValidS = 1'b1;
      drv(7'h01, 8);
      waitLvl(3, 1'b0, 30);
      r0 = rxResync;
      clkMQreqN = 1'b1;
      waitLvl(2, 1'b1, 5);
      waitRs(r0, 10);
      waitLvl(3, 1'b1, 30);
      @(negedge mclk);
      tsSyncValidS = 1'b0;
      $display("test master gating done");
      closeOut();
   end
endmodule
`default_nettype wire
